/* hw/prio_map_pkg.sv */
// Package for the middle slice of the TOS/traffic-class priority table.
// Holds register offsets, field layout, reset values and the carrier structs
// shared by the table top and its per-register storage module.
package prio_map_pkg;

    // ************************************************************
    // Register offsets on the internal management register port
    // ************************************************************
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_3 = 8'h63;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_4 = 8'h64;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_5 = 8'h65;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_6 = 8'h66;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_7 = 8'h67;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_8 = 8'h68;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_9 = 8'h69;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_10 = 8'h6A;
    localparam logic [7:0] ADDR_TOS_PRIORITY_MAP_11 = 8'h6B;

    // ************************************************************
    // Table geometry and field layout
    // ************************************************************
    localparam int MAP_COUNT = 9;
    localparam int CODES_PER_REG = 4;
    localparam int ENTRY_WIDTH = 2;
    localparam int CODE_WIDTH = 6;
    localparam int TOS_CODE_LSB = 2;
    localparam int TOS_CODE_MSB = 7;
    localparam logic [3:0] GROUP_FIRST = 4'h3;
    localparam logic [3:0] GROUP_LAST = 4'hB;
    localparam logic [7:0] MAP_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [1:0] PRIO_RESET = 2'h0;

    // ************************************************************
    // Carrier structs
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_rsp_s;

    typedef struct packed {
        logic valid;
        logic is_ip;
        logic [7:0] tos;
    } lookup_req_s;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [1:0] prio;
    } lookup_rsp_s;

    typedef struct packed {
        logic [7:0] value;
    } map_byte_state_s;

    typedef struct packed {
        lookup_rsp_s rsp;
        reg_rsp_s rd;
    } map_top_state_s;

endpackage

/* hw/prio_map_byte.sv */
// One byte-wide table register holding four 2-bit priority entries.
// Assumes the write strobe is already decoded for this register's offset.
`timescale 1ns/1ps
module prio_map_byte (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic [1:0] code_sel,
    output logic [7:0] value,
    output logic [1:0] entry
);

    prio_map_pkg::map_byte_state_s state;
    prio_map_pkg::map_byte_state_s next_state;

    // Software write replaces the whole byte
    always_comb begin
        next_state = state;
        if (wr_en) begin
            next_state.value = wdata;
        end
    end

    // All entries come up as lowest priority
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state.value <= prio_map_pkg::MAP_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign value = state.value;
    // Lowest code in bits 1-0, each next code two bits higher
    assign entry = state.value[code_sel * prio_map_pkg::ENTRY_WIDTH +: prio_map_pkg::ENTRY_WIDTH];

endmodule

/* hw/prio_map_mid.sv */
// Middle slice of the 64-entry TOS/traffic-class priority table: codes 0x0C-0x2F,
// kept in nine byte registers, plus the lookup used by ingress classification.
// Assumes a single-cycle internal register port and lookup requests on sys_clk.
// Functional notes
// - Index is TOS bits 7:2; the entry at that index is the priority.
// - Six-bit index decoded here for codes 0x0C-0x2F only, each its own 2-bit entry.
// - Codes 0x0C, 0x0D, 0x0E sit in bits 1-0, 3-2, 5-4 of that register.
// - Offset 0x64 holds codes 0x10-0x13, ascending from bits 1-0.
// - Offset 0x65 holds codes 0x14-0x17, 0x14 low, 0x17 in bits 7-6.
// - Offset 0x66 holds codes 0x18-0x1B, ascending from bits 1-0.
// - Offset 0x67 holds codes 0x1C-0x1F, 0x1C low, 0x1F in bits 7-6.
// - Offset 0x68 holds codes 0x20-0x23, ascending from bits 1-0.
// - Offset 0x69 holds codes 0x24-0x27, 0x24 low, 0x27 in bits 7-6.
// - Offset 0x6A holds codes 0x28-0x2B, ascending from bits 1-0.
// - Every entry is read/write and resets to 00.
// - Offset 0x6B holds codes 0x2C-0x2F in the same ascending layout.
`timescale 1ns/1ps
module prio_map_mid (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire prio_map_pkg::reg_req_s reg_req,
    output prio_map_pkg::reg_rsp_s reg_rsp,
    input wire prio_map_pkg::lookup_req_s lookup_req,
    output prio_map_pkg::lookup_rsp_s lookup_rsp
);

    // ************************************************************
    // Address decode
    // ************************************************************
    logic [prio_map_pkg::MAP_COUNT-1:0] sel;
    logic [7:0] map_value [prio_map_pkg::MAP_COUNT];
    logic [1:0] map_entry [prio_map_pkg::MAP_COUNT];
    logic [5:0] code;
    logic [3:0] group;
    logic [3:0] slot;
    logic in_range;

    // One-hot select; map_3 holds codes 0x0C-0x0F, map_11 holds 0x2C-0x2F
    always_comb begin
        sel = '0;
        case (reg_req.addr)
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_3: begin
                sel[0] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_4: begin
                sel[1] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_5: begin
                sel[2] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_6: begin
                sel[3] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_7: begin
                sel[4] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_8: begin
                sel[5] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_9: begin
                sel[6] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_10: begin
                sel[7] = 1'b1;
            end
            prio_map_pkg::ADDR_TOS_PRIORITY_MAP_11: begin
                sel[8] = 1'b1;
            end
            default: begin
                sel = '0;
            end
        endcase
    end

    // ************************************************************
    // Lookup index
    // ************************************************************
    // Upper six bits of the TOS byte form the code; code[5:2] picks the register
    assign code = lookup_req.tos[prio_map_pkg::TOS_CODE_MSB:prio_map_pkg::TOS_CODE_LSB];
    assign group = code[5:2];
    assign in_range = (group >= prio_map_pkg::GROUP_FIRST) && (group <= prio_map_pkg::GROUP_LAST);
    assign slot = group - prio_map_pkg::GROUP_FIRST;

    // ************************************************************
    // Table storage
    // ************************************************************
    // Same code_sel feeds every byte; the register mux below picks one entry
    genvar gi;
    generate
        for (gi = 0; gi < prio_map_pkg::MAP_COUNT; gi++) begin : g_map
            prio_map_byte u_byte (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .wr_en(reg_req.wr && sel[gi]),
                .wdata(reg_req.wdata),
                .code_sel(code[1:0]),
                .value(map_value[gi]),
                .entry(map_entry[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Registered answers
    // ************************************************************
    prio_map_pkg::map_top_state_s state;
    prio_map_pkg::map_top_state_s next_state;
    logic [7:0] rd_mux;

    // Read mux; unmapped offsets read as zero rather than stale data
    always_comb begin
        rd_mux = prio_map_pkg::READ_UNMAPPED;
        for (int i = 0; i < prio_map_pkg::MAP_COUNT; i++) begin
            if (sel[i]) begin
                rd_mux = map_value[i];
            end
        end
    end

    // Lookup sees the table as it stood before a same-cycle write
    always_comb begin
        next_state = state;
        next_state.rd.valid = reg_req.rd;
        if (reg_req.rd) begin
            next_state.rd.data = rd_mux;
        end
        next_state.rsp.valid = lookup_req.valid && lookup_req.is_ip;
        next_state.rsp.hit = 1'b0;
        next_state.rsp.prio = prio_map_pkg::PRIO_RESET;
        if (lookup_req.valid && lookup_req.is_ip && in_range) begin
            // Codes outside 0x0C-0x2F belong to other slices; answer with no hit
            next_state.rsp.hit = 1'b1;
            next_state.rsp.prio = map_entry[slot];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state.rsp.valid <= 1'b0;
            state.rsp.hit <= 1'b0;
            state.rsp.prio <= prio_map_pkg::PRIO_RESET;
            state.rd.valid <= 1'b0;
            state.rd.data <= prio_map_pkg::READ_UNMAPPED;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rsp = state.rd;
    assign lookup_rsp = state.rsp;

endmodule

/* verif/prio_map_mid_chk.sv */
// Checker for the priority table slice: register and lookup port timing.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module prio_map_mid_chk (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire prio_map_pkg::reg_req_s reg_req,
    input wire prio_map_pkg::reg_rsp_s reg_rsp,
    input wire prio_map_pkg::lookup_req_s lookup_req,
    input wire prio_map_pkg::lookup_rsp_s lookup_rsp
);
    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic ip_req;
    logic in_range;
    // Lookups that must be answered, and codes this slice owns
    assign ip_req = lookup_req.valid && lookup_req.is_ip;
    assign in_range = lookup_req.tos[7:2] inside {[6'h0C:6'h2F]};
    read_answer_a: assert property (reg_req.rd |=> reg_rsp.valid)
        else $error("read without answer");
    no_stray_a: assert property (!reg_req.rd |=> !reg_rsp.valid && $stable(reg_rsp.data))
        else $error("read answer without read");
    unmapped_zero_a: assert property (reg_req.rd && !(reg_req.addr inside {[8'h63:8'h6B]}) |=> reg_rsp.data == 8'h00)
        else $error("unmapped read not zero");
    write_read_a: assert property (reg_req.wr && !reg_req.rd && reg_req.addr inside {[8'h63:8'h6B]} ##1
        reg_req.rd && reg_req.addr == $past(reg_req.addr) |=> reg_rsp.data == $past(reg_req.wdata, 2)) else $error("readback wrong");
    lookup_answer_a: assert property (ip_req |=> lookup_rsp.valid)
        else $error("lookup not answered");
    non_ip_a: assert property (!ip_req |=> !lookup_rsp.valid)
        else $error("non-IP frame answered");
    hit_a: assert property (ip_req && in_range |=> lookup_rsp.hit)
        else $error("owned code missed");
    miss_a: assert property (ip_req && !in_range |=> !lookup_rsp.hit && lookup_rsp.prio == 2'h0)
        else $error("foreign code answered");
    // Main scenarios reached
    cover property (reg_req.rd ##1 reg_rsp.valid);
    cover property (ip_req && in_range ##1 lookup_rsp.prio == 2'h3);
    cover property (lookup_req.valid && !lookup_req.is_ip);
endmodule

/* verif/prio_map_mid_test.sv */
// Testbench for the priority table slice: register access and lookups.
// Inputs change at the falling edge; answers are checked at the next falling edge.
`timescale 1ns/1ps
module prio_map_mid_test;
    logic sys_clk;
    logic resetn;
    prio_map_pkg::reg_req_s reg_req;
    prio_map_pkg::reg_rsp_s reg_rsp;
    prio_map_pkg::lookup_req_s lookup_req;
    prio_map_pkg::lookup_rsp_s lookup_rsp;
    logic [7:0] shadow [0:255];
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    // ********************************
    // Clock, timeout and design
    // ********************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Run is about 115 cycles, so 1000 means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            fail_count++;
            stop_test();
        end
    end
    prio_map_mid u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .lookup_req(lookup_req), .lookup_rsp(lookup_rsp));
    // ********************************
    // Tasks
    // ********************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        reg_req = '0;
        lookup_req = '0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        for (int i = 0; i < 256; i++) shadow[i] = 8'h00;
    endtask
    // Only the nine table offsets keep what is written
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        lookup_req = '0;
        @(negedge sys_clk);
        if (addr inside {[8'h63:8'h6B]}) shadow[addr] = data;
    endtask
    task automatic reg_read(input logic [7:0] addr);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        lookup_req = '0;
        @(negedge sys_clk);
        check("rsp_valid", 8'h01, {7'h00, reg_rsp.valid});
        check("rsp_data", shadow[addr], reg_rsp.data);
    endtask
    // Low TOS bits set to 10 to prove they are ignored
    task automatic lookup(input logic [5:0] code, input logic is_ip);
        logic hit;
        logic [7:0] b;
        hit = is_ip && code inside {[6'h0C:6'h2F]};
        b = shadow[{4'h6, code[5:2]}];
        lookup_req = '{valid: 1'b1, is_ip: is_ip, tos: {code, 2'b10}};
        reg_req = '0;
        @(negedge sys_clk);
        check("lookup_rsp", {4'h0, is_ip, hit, hit ? b[2 * code[1:0] +: 2] : 2'h0}, {4'h0, lookup_rsp});
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ********************************
    // Sequence
    // ********************************
    initial begin
        resetn = 1'b0;
        reg_req = '0;
        lookup_req = '0;
        // Reset spans exactly five rising edges from time zero
        do_reset();
        for (int a = 8'h62; a <= 8'h6C; a++) reg_read(8'(a));
        for (int a = 8'h62; a <= 8'h6C; a++) reg_write(8'(a), {a[3:0], ~a[3:0]});
        for (int a = 8'h62; a <= 8'h6C; a++) reg_read(8'(a));
        for (int c = 0; c < 64; c++) lookup(6'(c), 1'b1);
        lookup(6'h13, 1'b0);
        reg_write(8'h64, 8'hE4);
        reg_read(8'h64);
        reg_write(8'h6B, 8'h1B);
        lookup(6'h2C, 1'b1);
        do_reset();
        reg_read(8'h68);
        lookup(6'h20, 1'b1);
        stop_test();
    end
endmodule
bind prio_map_mid prio_map_mid_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .lookup_req(lookup_req), .lookup_rsp(lookup_rsp));
